// ---- design/ttx_ctrl.sv ----
`timescale 1ns/1ps
`include "ttx_consts.svh"

module ttx_ctrl
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sync pins, asynchronous
    input  wire logic        hsync_pin,
    input  wire logic        vsync_pin,
    output logic             hsync_ref,
    output logic             vsync_ref,
    output logic             field_pol_late,
    // Acquisition engine side
    input  wire logic        pkt_valid,
    input  wire logic [4:0]  pkt_num,
    input  wire logic        pkt_is_ext,
    input  wire logic        on_data_line,
    input  wire logic        enh_done_evt,
    input  wire logic        wss_done_evt,
    input  wire logic        done_clear,
    output logic             acq_mem_wr_en,
    output logic             row24_store_place,
    output logic             raw_byte_mode,
    output logic             enhancement_proc_off,
    output logic             programme_delivery_capture_en,
    output logic             inventory_capture_en,
    output logic             widescreen_acq_en,
    output logic             video_input_sel,
    output logic             sel_a,
    output logic      [3:0]  page_request_selector,
    output logic      [2:0]  page_request_start_col,
    output logic      [4:0]  page_request_value_bits,
    // Display generator side
    input  wire logic        video_shown,
    input  wire logic        frame_req,
    input  wire logic [4:0]  disp_row,
    output logic             frame_out,
    output logic      [4:0]  mem_row,
    output logic             row_visible,
    output logic             row_box_en,
    output logic             row24_show_source,
    output logic      [7:0]  render_ctrl,
    output logic      [7:0]  box_ctrl_first,
    output logic      [7:0]  box_ctrl_second,
    output logic             cursor_en,
    output logic             show_hidden_chars,
    output logic             alt_onscreen_bank_en,
    output logic             eastern_language_sel,
    output logic             line_filter_off,
    output logic             special_char_tweak_off
);

    // ************************************************
    // State
    // ************************************************
    // Current and next copy of the whole bank
    ttx_pkg::ttx_state_t st_r;
    ttx_pkg::ttx_state_t st_nxt;

    // Bus strobes and read byte
    logic       wr_go;
    logic       rd_setup;
    logic       addr_ok;
    logic [7:0] rd_byte;

    // Sync edges seen after the synchronisers
    logic       hs_fall;
    logic       hs_rise;
    logic       vs_fall;
    logic       vs_rise;

    // Packet gate and row mapping
    logic       pkt_ok;
    logic [4:0] row_calc;

    // Field aliases of control register a
    logic c_store_page;
    logic c_show_ext;
    logic c_auto_frame;
    logic c_hdr_roll_off;
    logic c_status_only;
    logic c_frame_off;

    // Field aliases of control register b
    logic c_ext_off;
    logic c_raw;
    logic c_acq_write_off;
    logic c_enh_off;
    logic c_full_field;
    logic c_field_pol;
    logic c_h_fall;
    logic c_v_fall;

    // Field aliases of the row and cursor register
    logic c_status_top;
    logic c_tall;
    logic c_tall_half;
    logic c_box_last;
    logic c_box_body;
    logic c_box_first;

    // Control fields named once, so the logic reads by behaviour
    assign c_store_page   = st_r.ctrl_a[7];
    assign c_show_ext     = st_r.ctrl_a[6];
    assign c_auto_frame   = st_r.ctrl_a[5];
    assign c_hdr_roll_off = st_r.ctrl_a[4];
    assign c_status_only  = st_r.ctrl_a[3];
    assign c_frame_off    = st_r.ctrl_a[2];

    // Acquisition control fields
    assign c_ext_off      = st_r.ctrl_b[7];
    assign c_raw          = st_r.ctrl_b[6];
    assign c_acq_write_off      = st_r.ctrl_b[5];
    assign c_enh_off      = st_r.ctrl_b[4];
    assign c_full_field   = st_r.ctrl_b[3];
    assign c_field_pol    = st_r.ctrl_b[2];
    assign c_h_fall       = st_r.ctrl_b[1];
    assign c_v_fall       = st_r.ctrl_b[0];

    // Row and box fields
    assign c_status_top   = st_r.row_cur[7];
    assign c_tall_half    = st_r.row_cur[4];
    assign c_tall         = st_r.row_cur[3];
    assign c_box_last     = st_r.row_cur[2];
    assign c_box_body     = st_r.row_cur[1];
    assign c_box_first    = st_r.row_cur[0];

    // ************************************************
    // APB decode
    // ************************************************
    // Zero wait states; unmapped words answer with an error.
    // Read data is taken at the end of setup, so a read right after
    // a write already sees the new value.
    // pslverr is raised only in the access phase.
    assign pready   = 1'b1;
    assign wr_go    = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pslverr  = psel & penable & ~addr_ok;

    // Address match and read mux; the done flags are spliced in
    // here, so no write path reaches them.
    // Reads of unmapped words return zero.
    always_comb
    begin
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            `TTX_OFS_CTRL_A:   rd_byte = st_r.ctrl_a;
            `TTX_OFS_CTRL_B:   rd_byte = st_r.ctrl_b;
            `TTX_OFS_REQ_SEL:  rd_byte = st_r.req_sel;
            `TTX_OFS_REQ_VAL:  rd_byte = {3'h0, st_r.req_val};
            `TTX_OFS_RENDER:   rd_byte = st_r.render;
            `TTX_OFS_BOX_1:    rd_byte = st_r.box_1;
            `TTX_OFS_BOX_2:    rd_byte = st_r.box_2;
            `TTX_OFS_ROW_CUR:  rd_byte = st_r.row_cur;
            `TTX_OFS_SRC_STAT:
            begin
                rd_byte = st_r.src_ctl;
                rd_byte[`TTX_B_ENH_DONE] = st_r.enh_done;
                rd_byte[`TTX_B_WSS_DONE] = st_r.wss_done;
            end
            default:           addr_ok = 1'b0;
        endcase
    end

    // ************************************************
    // Sync edge detection
    // ************************************************
    // Only the second and third stages are looked at; the first
    // may be metastable and feeds nothing but the second.
    // The chain clears to zero, so a pin idling high gives one
    // rising edge after reset.
    // Software should set polarity before trusting pulses.
    assign hs_fall = st_r.hs_sync[2] & ~st_r.hs_sync[1];
    assign hs_rise = ~st_r.hs_sync[2] & st_r.hs_sync[1];
    assign vs_fall = st_r.vs_sync[2] & ~st_r.vs_sync[1];
    assign vs_rise = ~st_r.vs_sync[2] & st_r.vs_sync[1];

    // ************************************************
    // Acquisition gating
    // ************************************************
    // Header roll off only blocks packet 0; lines other than data lines
    // need the full-field override to pass.
    // The tests are independent, so their order does not matter.
    // Inputs share the clock, so no synchroniser is needed.
    // The strobe is registered to keep the memory path short.
    always_comb
    begin
        pkt_ok = pkt_valid;
        if (c_acq_write_off)
            pkt_ok = 1'b0;
        if (~on_data_line & ~c_full_field)
            pkt_ok = 1'b0;
        if (pkt_is_ext & c_ext_off)
            pkt_ok = 1'b0;
        if (c_hdr_roll_off && pkt_num == `TTX_PKT_HEADER)
            pkt_ok = 1'b0;
    end

    // ************************************************
    // Display row mapping
    // ************************************************
    // Double height shows half the page, two lines per memory row.
    // The status row override comes last, so it wins in double
    // height too; the half-page offset stays within five bits.
    always_comb
    begin
        row_calc = disp_row;
        if (c_tall)
        begin
            row_calc = {1'b0, disp_row[4:1]};
            if (c_tall_half)
                row_calc = row_calc + `TTX_ROW_HALF;
        end
        if (c_status_top && disp_row == 5'h00)
            row_calc = `TTX_ROW_STATUS;
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        // Hold every field unless a term below changes it
        st_nxt = st_r;

        // Register writes, low byte only; unmapped offsets change
        // nothing and the bus sees an error instead
        if (wr_go)
        begin
            case (paddr)
                `TTX_OFS_CTRL_A:   st_nxt.ctrl_a  = pwdata[7:0];
                `TTX_OFS_CTRL_B:   st_nxt.ctrl_b  = pwdata[7:0];
                `TTX_OFS_REQ_SEL:  st_nxt.req_sel = pwdata[7:0];
                `TTX_OFS_REQ_VAL:  st_nxt.req_val = pwdata[4:0];
                `TTX_OFS_RENDER:   st_nxt.render  = pwdata[7:0];
                `TTX_OFS_BOX_1:    st_nxt.box_1   = pwdata[7:0];
                `TTX_OFS_BOX_2:    st_nxt.box_2   = pwdata[7:0];
                `TTX_OFS_ROW_CUR:  st_nxt.row_cur = pwdata[7:0];
                `TTX_OFS_SRC_STAT:
                    st_nxt.src_ctl = pwdata[7:0]
                                   & `TTX_SRC_CTRL_MASK;
                default:           st_nxt.src_ctl = st_r.src_ctl;
            endcase
        end

        // Read data captured in setup so it leaves a flip-flop
        // and stands still through the access phase
        if (rd_setup)
            st_nxt.prdata = {24'h0, rd_byte};

        // Done flags: hardware clear, set wins over it.
        // An event in the clear cycle must not be lost, so the set
        // terms come after the clear.
        if (done_clear)
        begin
            st_nxt.enh_done = 1'b0;
            st_nxt.wss_done = 1'b0;
        end
        if (enh_done_evt & ~c_enh_off)
            st_nxt.enh_done = 1'b1;
        if (wss_done_evt & st_r.src_ctl[3])
            st_nxt.wss_done = 1'b1;

        // Two-stage synchronisers plus one stage for edges
        // Reference pulses last one clock, on the chosen edge
        st_nxt.hs_sync = {st_r.hs_sync[1:0], hsync_pin};
        st_nxt.vs_sync = {st_r.vs_sync[1:0], vsync_pin};
        st_nxt.hs_ref  = c_h_fall ? hs_fall : hs_rise;
        st_nxt.vs_ref  = c_v_fall ? vs_fall : vs_rise;

        // Overlay blanking; disable overrides auto.
        // Registered, so the pin cannot glitch while the request
        // and the video flag settle.
        // The output idles low after reset.
        st_nxt.frame = frame_req;
        if (c_auto_frame & video_shown)
            st_nxt.frame = 1'b0;
        if (c_frame_off)
            st_nxt.frame = 1'b0;

        // Memory write strobe, one cycle after the packet strobe
        st_nxt.acq_wr = pkt_ok;

        // Row visibility and box enable per memory row.
        // The box bit is picked by the mapped row, not the display
        // row, so the status row keeps its own box bit on top.
        st_nxt.mem_row = row_calc;
        st_nxt.row_vis = ~c_status_only
                       | (row_calc == `TTX_ROW_STATUS);
        if (row_calc == 5'h00)
            st_nxt.box_en = c_box_first;
        else if (row_calc == `TTX_ROW_STATUS)
            st_nxt.box_en = c_box_last;
        else
            st_nxt.box_en = c_box_body;
    end

    // ************************************************
    // State register
    // ************************************************
    // Everything clears to zero: enable bits start off, while disable bits such as c_enh_off leave their features on.
    // One struct under one reset: no field can miss the clear.
    // Reset is asynchronous; its release must be clean on clk.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ************************************************
    // Outputs
    // ************************************************
    // Bus and sync outputs
    assign prdata         = st_r.prdata;
    assign hsync_ref      = st_r.hs_ref;
    assign vsync_ref      = st_r.vs_ref;
    assign field_pol_late = c_field_pol;

    // Acquisition side levels
    assign acq_mem_wr_en        = st_r.acq_wr;
    assign row24_store_place    = c_store_page;
    assign raw_byte_mode        = c_raw;
    assign enhancement_proc_off = c_enh_off;
    assign programme_delivery_capture_en = st_r.ctrl_a[1];
    assign inventory_capture_en = st_r.ctrl_a[0];
    assign widescreen_acq_en    = st_r.src_ctl[3];
    assign video_input_sel      = st_r.src_ctl[2];

    // Page request fields
    assign sel_a                   = st_r.req_sel[7];
    assign page_request_selector   = st_r.req_sel[6:3];
    assign page_request_start_col  = st_r.req_sel[2:0];
    assign page_request_value_bits = st_r.req_val;

    // Display controls
    assign frame_out         = st_r.frame;
    assign mem_row           = st_r.mem_row;
    assign row_visible       = st_r.row_vis;
    assign row_box_en        = st_r.box_en;

    // Row 24 source
    assign row24_show_source = c_show_ext;

    // Character and box options
    assign render_ctrl       = st_r.render;
    assign box_ctrl_first    = st_r.box_1;
    assign box_ctrl_second   = st_r.box_2;

    // Cursor, show_hidden_chars and character set
    assign cursor_en         = st_r.row_cur[6];
    assign show_hidden_chars = st_r.row_cur[5];
    assign alt_onscreen_bank_en = st_r.render[7];
    assign eastern_language_sel = st_r.render[5];

    // Source register levels with no logic behind them here
    assign line_filter_off        = st_r.src_ctl[7];
    assign special_char_tweak_off = st_r.src_ctl[6];

endmodule

// ---- inc/ttx_consts.svh ----
`ifndef TTX_CONSTS_SVH
`define TTX_CONSTS_SVH

// Register byte offsets
`define TTX_OFS_CTRL_A    8'h00
`define TTX_OFS_CTRL_B    8'h04
`define TTX_OFS_REQ_SEL   8'h08
`define TTX_OFS_REQ_VAL   8'h0c
`define TTX_OFS_RENDER    8'h10
`define TTX_OFS_BOX_1     8'h14
`define TTX_OFS_BOX_2     8'h18
`define TTX_OFS_ROW_CUR   8'h1c
`define TTX_OFS_SRC_STAT  8'h20
`define TTX_RST_VAL       8'h00

// Status register flag and control positions
`define TTX_B_ENH_DONE    5
`define TTX_B_WSS_DONE    4
`define TTX_SRC_CTRL_MASK 8'hcc

// Memory rows and packet number of interest
`define TTX_ROW_STATUS    5'h18
`define TTX_ROW_HALF      5'h0c
`define TTX_PKT_HEADER    5'h00
`endif

// ---- inc/ttx_pkg.sv ----
package ttx_pkg;
    // All state of the register bank
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [7:0]  req_sel;
        logic [4:0]  req_val;
        logic [7:0]  render;
        logic [7:0]  box_1;
        logic [7:0]  box_2;
        logic [7:0]  row_cur;
        logic [7:0]  src_ctl;
        logic        enh_done;
        logic        wss_done;
        logic [2:0]  hs_sync;
        logic [2:0]  vs_sync;
        logic        hs_ref;
        logic        vs_ref;
        logic [31:0] prdata;
        logic        frame;
        logic        acq_wr;
        logic [4:0]  mem_row;
        logic        row_vis;
        logic        box_en;
    } ttx_state_t;
endpackage

// ---- tb/tadc_ctrl_assertions.sv ----
`timescale 1ns/1ps
// ****************************************
// Checker on the register bank ports
// ****************************************
module tadc_ctrl_assertions
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Acquisition and display
    input wire logic        pkt_valid,
    input wire logic        acq_mem_wr_en,
    input wire logic        frame_req,
    input wire logic        frame_out,
    input wire logic        hsync_ref,
    input wire logic        row24_store_place,
    input wire logic        sel_a,
    input wire logic [3:0]  page_request_selector,
    input wire logic [2:0]  page_request_start_col,
    input wire logic [7:0]  render_ctrl,
    input wire logic [7:0]  box_ctrl_first
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] wd_q;
    wire        wr = psel && penable && pwrite;
    // Last write data, so a commit can be compared a cycle later
    always_ff @(posedge clk or posedge rst)
        if (rst)
            wd_q <= 8'h00;
        else
            wd_q <= pwdata[7:0];
    // Bus answer and refusals
    pready_high_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    unmapped_err_a: assert property (
        psel && penable && paddr > 8'h20 |-> pslverr)
        else $error("no error on unmapped");
    status_zero_a: assert property (psel && penable && !pwrite &&
        paddr == 8'h20 |-> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
        else $error("status spare bits set");
    // Control levels follow the committed write
    store_place_a: assert property (wr && paddr == 8'h00 |=>
        row24_store_place == wd_q[7]) else $error("store place stale");
    page_req_a: assert property (wr && paddr == 8'h08 |=>
        {sel_a, page_request_selector, page_request_start_col} == wd_q)
        else $error("page request stale");
    render_upd_a: assert property (wr && paddr == 8'h10 |=>
        render_ctrl == wd_q) else $error("render stale");
    box_upd_a: assert property (wr && paddr == 8'h14 |=>
        box_ctrl_first == wd_q) else $error("box stale");
    // Outputs need a cause one cycle before; hsync pulses last one cycle
    acq_cause_a: assert property (
        acq_mem_wr_en |-> $past(pkt_valid))
        else $error("write without packet");
    frame_cause_a: assert property (frame_out |-> $past(frame_req))
        else $error("frame without request");
    sync_pulse_a: assert property (hsync_ref |=> !hsync_ref)
        else $error("sync pulse too long");
endmodule

bind ttx_ctrl tadc_ctrl_assertions tadc_ctrl_assertions_inst (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pkt_valid(pkt_valid), .frame_out(frame_out),
    .acq_mem_wr_en(acq_mem_wr_en), .frame_req(frame_req),
    .hsync_ref(hsync_ref), .row24_store_place(row24_store_place),
    .sel_a(sel_a), .page_request_selector(page_request_selector),
    .page_request_start_col(page_request_start_col),
    .render_ctrl(render_ctrl), .box_ctrl_first(box_ctrl_first));

// ---- tb/teletext_acq_display_ctrl_tb.sv ----
`timescale 1ns/1ps
module teletext_acq_display_ctrl_tb;
    // ****************************************
    // Signals and bench state
    // ****************************************
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, render_ctrl, box_ctrl_first, box_ctrl_second;
    logic [31:0] pwdata, prdata, rd, r;
    logic        hsync_pin, vsync_pin, hsync_ref, vsync_ref, field_pol_late;
    logic        pkt_valid, pkt_is_ext, on_data_line, acq_mem_wr_en;
    logic [4:0]  pkt_num, disp_row, mem_row, page_request_value_bits;
    logic        enh_done_evt, wss_done_evt, done_clear, video_shown;
    logic        frame_req, frame_out, row_visible, row_box_en, sel_a;
    logic        row24_store_place, raw_byte_mode, enhancement_proc_off;
    logic        programme_delivery_capture_en, inventory_capture_en;
    logic        widescreen_acq_en, video_input_sel, row24_show_source;
    logic        cursor_en, show_hidden_chars, alt_onscreen_bank_en;
    logic        eastern_language_sel, line_filter_off;
    logic        special_char_tweak_off;
    logic [3:0]  page_request_selector;
    logic [2:0]  page_request_start_col;
    logic [7:0]  m [9];
    int          seed = 32'h1cb8;
    int          n_mismatch, checked, ch, cv;
    ttx_ctrl ttx_ctrl_inst (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .hsync_ref(hsync_ref),
        .vsync_ref(vsync_ref), .field_pol_late(field_pol_late),
        .pkt_valid(pkt_valid), .pkt_num(pkt_num), .pkt_is_ext(pkt_is_ext),
        .on_data_line(on_data_line), .enh_done_evt(enh_done_evt),
        .wss_done_evt(wss_done_evt), .done_clear(done_clear),
        .acq_mem_wr_en(acq_mem_wr_en), .row24_store_place(row24_store_place),
        .raw_byte_mode(raw_byte_mode), .sel_a(sel_a),
        .enhancement_proc_off(enhancement_proc_off),
        .programme_delivery_capture_en(programme_delivery_capture_en),
        .inventory_capture_en(inventory_capture_en),
        .widescreen_acq_en(widescreen_acq_en),
        .video_input_sel(video_input_sel),
        .page_request_selector(page_request_selector),
        .page_request_start_col(page_request_start_col),
        .page_request_value_bits(page_request_value_bits),
        .video_shown(video_shown), .frame_req(frame_req),
        .disp_row(disp_row), .frame_out(frame_out), .mem_row(mem_row),
        .row_visible(row_visible), .row_box_en(row_box_en),
        .row24_show_source(row24_show_source), .render_ctrl(render_ctrl),
        .box_ctrl_first(box_ctrl_first), .box_ctrl_second(box_ctrl_second),
        .cursor_en(cursor_en), .show_hidden_chars(show_hidden_chars),
        .alt_onscreen_bank_en(alt_onscreen_bank_en),
        .eastern_language_sel(eastern_language_sel),
        .line_filter_off(line_filter_off),
        .special_char_tweak_off(special_char_tweak_off));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle edge follows so strobes never clash
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Write raw data, model keeps only the writable bits
    task wr(input int i, input logic [7:0] d);
        m[i] = d & (i == 3 ? 8'h1f : i == 8 ? 8'hcc : 8'hff);
        apb(8'(i * 4), 1'b1, {24'h0, d});
    endtask
    task cnt_ref;
        ch = 0;
        cv = 0;
        repeat (8)
        begin
            @(negedge clk);
            ch += int'(hsync_ref === 1'b1);
            cv += int'(vsync_ref === 1'b1);
        end
        @(posedge clk);
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Free running clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, hsync_pin, vsync_pin} = '0;
        {pkt_valid, pkt_num, pkt_is_ext, on_data_line, enh_done_evt} = 0;
        {wss_done_evt, done_clear, video_shown, frame_req, disp_row} = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            apb(8'(i * 4), 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        apb(8'h24, 1'b1, 32'hff);
        apb(8'h24, 1'b0, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        for (int k = 0; k < 5; k++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                r = $random(seed);
                wr(i, k == 0 ? 8'hff : r[7:0]);
            end
            for (int i = 0; i < 9; i++)
            begin
                apb(8'(i * 4), 1'b0, 32'h0);
                chk(rd, {24'h0, m[i]});
            end
            chk({row24_store_place, row24_show_source, raw_byte_mode,
                programme_delivery_capture_en, inventory_capture_en,
                enhancement_proc_off, field_pol_late}, {m[0][7:6],
                m[1][6], m[0][1:0], m[1][4],
                m[1][2]});
            chk({sel_a, page_request_selector, page_request_start_col,
                page_request_value_bits}, {m[2], m[3][4:0]});
            chk({render_ctrl, alt_onscreen_bank_en, eastern_language_sel},
                {m[4], m[4][7], m[4][5]});
            chk({box_ctrl_first, box_ctrl_second}, {m[5], m[6]});
            chk({cursor_en, show_hidden_chars, line_filter_off,
                special_char_tweak_off, widescreen_acq_en, video_input_sel},
                {m[7][6:5], m[8][7:6], m[8][3:2]});
        end
        repeat (24)
        begin
            r = $random(seed);
            wr(0, r[7:0]);
            wr(1, r[15:8]);
            pkt_valid <= 1'b1;
            pkt_num <= {4'h0, r[16]};
            pkt_is_ext <= r[17];
            on_data_line <= r[18];
            @(posedge clk);
            pkt_valid <= 1'b0;
            @(negedge clk);
            chk(acq_mem_wr_en, !m[1][5] && (r[18] || m[1][3]) &&
                !(r[17] && m[1][7]) &&
                !(!r[16] && m[0][4]));
            @(posedge clk);
        end
        frame_req <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            wr(0, {2'h0, k[2], 2'h0, k[1], 2'h0});
            video_shown <= k[0];
            repeat (2) @(posedge clk);
            chk(frame_out, !k[1] && !(k[2] && k[0]));
        end
        for (int p = 0; p < 2; p++)
        begin
            wr(1, {6'h0, p[0], p[0]});
            {hsync_pin, vsync_pin} <= 2'h3;
            cnt_ref;
            chk({ch, cv}, {32'(1 - p), 32'(1 - p)});
            {hsync_pin, vsync_pin} <= 2'h0;
            cnt_ref;
            chk({ch, cv}, {32'(p), 32'(p)});
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(1, k == 1 ? 8'h10 : 8'h00);
            wr(8, k == 1 ? 8'h00 : 8'h08);
            {enh_done_evt, wss_done_evt, done_clear} <= 3'h7;
            @(posedge clk);
            {enh_done_evt, wss_done_evt, done_clear} <= 3'h0;
            @(posedge clk);
            apb(8'h20, 1'b0, 32'h0);
            chk(rd, k == 1 ? 32'h0 : 32'h38);
            done_clear <= 1'b1;
            @(posedge clk);
            done_clear <= 1'b0;
            apb(8'h20, 1'b0, 32'h0);
            chk(rd, {24'h0, m[8]});
        end
        for (int j = 0; j < 4; j++)
        begin
            wr(7, j == 0 ? 8'h80 : j == 1 ? 8'h18 : j == 2 ? 8'h01 : 8'h02);
            disp_row <= j == 1 ? 5'h04 : 5'h00;
            repeat (2) @(posedge clk);
            chk({mem_row, row_box_en}, j == 0 ? {5'h18, 1'b0} :
                j == 1 ? {5'h0e, 1'b0} :
                {5'h00, j == 2});
        end
        wr(0, 8'h08);
        for (int j = 0; j < 2; j++)
        begin
            disp_row <= j == 1 ? 5'h18 : 5'h05;
            repeat (2) @(posedge clk);
            chk(row_visible, j == 1);
        end
        report_and_stop;
    end
endmodule
